// >>> hb_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module hb_monitor
#(
    parameter logic [31:0] STUCK_CYCLES = 32'd3000000000
)
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic hb_i,
    output logic trip_o
);
    import relay_wd_pkg::*;

    logic hb_prev_q;
    logic [CNT_W-1:0] cnt_q;
    logic toggled;

    assign toggled = hb_i != hb_prev_q;

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            hb_prev_q <= 1'b0;
        else
            hb_prev_q <= hb_i;
    end

    // counter saturates at the limit so the trip holds steady
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            cnt_q <= '0;
        else if (toggled)
            cnt_q <= '0;
        else if (cnt_q < STUCK_CYCLES)
            cnt_q <= cnt_q + 32'd1;
    end

    // stuck on or off for the full time; cleared by the next toggle
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            trip_o <= 1'b0;
        else if (toggled)
            trip_o <= 1'b0;
        else if (cnt_q >= STUCK_CYCLES - 32'd1)
            trip_o <= 1'b1;
    end
endmodule : hb_monitor
`default_nettype wire

// >>> host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model
(
    input wire logic clk_i,
    input wire logic en_i,
    output logic hb_o = 1'b0
);
    logic [3:0] cnt_q = 4'h0;
    // a dead host freezes the level, it never floats
    always @(posedge clk_i)
    begin
        cnt_q <= cnt_q + 4'h1;
        if (en_i && cnt_q == 4'hf)
            hb_o <= ~hb_o;
    end
endmodule : host_model
`default_nettype wire

// >>> relay_board_watchdog_status.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - heartbeat stuck thirty seconds declares host failure
// - failure forces all valve outputs closed
// - failure switches off UV source and heaters
// - sample pump unaffected by watchdog trip
// - heater zone indicator follows heater drive
// - zero/span indicator lit on span path
// - sample/cal indicator lit on cal path
// - two valve units, four valves each
// - host commands arrive over I2C as master
// - outputs except the watchdog trip held at defaults until host control
module relay_board_watchdog_status
    import relay_wd_pkg::*;
#(
    parameter logic [31:0] STUCK_CYCLES = 32'(STUCK_CYCLES_DEF)
)
(
    input wire logic MCLK_I,
    input wire logic RST_N_I,
    input wire logic HOST_READY_I,
    input wire logic HEARTBEAT_CMD_I,
    input wire logic [relay_wd_pkg::VALVE_N-1:0] VALVE_CMD_I,
    input wire logic [relay_wd_pkg::HEATER_N-1:0] HEATER_CMD_I,
    input wire logic UV_CMD_I,
    input wire logic SHUTTER_CMD_I,
    input wire logic PUMP_CMD_I,
    output logic [relay_wd_pkg::VALVE_N-1:0] VALVE_O,
    output logic [relay_wd_pkg::HEATER_N-1:0] HEATER_O,
    output logic UV_O,
    output logic SHUTTER_O,
    output logic PUMP_O,
    output logic HEARTBEAT_INDICATOR_O,
    output logic CHAMBER_HEATER_INDICATOR_O,
    output logic PERM_TUBE_HEATER_INDICATOR_O,
    output logic ZERO_SPAN_VALVE_INDICATOR_O,
    output logic SAMPLE_CAL_VALVE_INDICATOR_O,
    output logic SHUTTER_INDICATOR_O,
    output logic WATCHDOG_TRIP_O
);
    import relay_wd_pkg::*;

    // command inputs are decoded I2C writes on this clock, no sync
    logic host_ok_q;
    logic trip;
    logic force_off;

    // next state of each output, registered below
    logic hb_ind_d;
    logic hb_ind_q;
    logic [VALVE_N-1:0] valve_d;
    logic [VALVE_N-1:0] valve_q;
    logic [HEATER_N-1:0] heater_d;
    logic [HEATER_N-1:0] heater_q;
    logic uv_d;
    logic uv_q;
    logic shutter_d;
    logic shutter_q;
    logic pump_d;
    logic pump_q;

    // defaults until host says it runs; once up, stays up until reset
    always_ff @(posedge MCLK_I)
    begin
        if (!RST_N_I)
            host_ok_q <= 1'b0;
        else if (HOST_READY_I)
            host_ok_q <= 1'b1;
    end

    // trip and boot hold share one forced-off path
    // boot hold reuses it so the power-up state is the safe one
    assign force_off = trip || !host_ok_q;

    // the host keeps the indicator toggling; we only watch it
    // trip clears on the next toggle, not on boot hold
    hb_monitor #(
        .STUCK_CYCLES(STUCK_CYCLES)
    ) u_hb (
        .clk_i(MCLK_I),
        .rst_n_i(RST_N_I),
        .hb_i(hb_ind_q),
        .trip_o(trip)
    );

    // watched after the register, so a dead link shows as a frozen lamp
    always_comb
    begin
        hb_ind_d = hb_ind_q;
        if (host_ok_q)
            hb_ind_d = HEARTBEAT_CMD_I;
    end

    always_ff @(posedge MCLK_I)
    begin
        if (!RST_N_I)
            hb_ind_q <= 1'b0;
        else
            hb_ind_q <= hb_ind_d;
    end

    // forced closed whatever the host last wrote
    always_comb
    begin
        valve_d = VALVE_CMD_I;
        if (force_off)
            valve_d = '0;
    end

    // two driver units of four channels each
    // flat index keeps the unit split out of the port list
    genvar u;
    genvar c;
    generate
        for (u = 0; u < int'(VALVE_UNITS); u++)
        begin : g_unit
            for (c = 0; c < int'(VALVES_PER_UNIT); c++)
            begin : g_chan
                localparam int unsigned IDX = u * VALVES_PER_UNIT + c;
                always_ff @(posedge MCLK_I)
                begin
                    if (!RST_N_I)
                        valve_q[IDX] <= VALVE_RST[IDX];
                    else
                        valve_q[IDX] <= valve_d[IDX];
                end
            end
        end
    endgenerate

    // lamp source goes dark with the heaters
    always_comb
    begin
        heater_d = HEATER_CMD_I;
        uv_d = UV_CMD_I;
        if (force_off)
        begin
            heater_d = '0;
            uv_d = 1'b0;
        end
    end

    // one register per heater zone
    // per-zone reset value, both zones start off
    genvar h;
    generate
        for (h = 0; h < int'(HEATER_N); h++)
        begin : g_heater
            always_ff @(posedge MCLK_I)
            begin
                if (!RST_N_I)
                    heater_q[h] <= HEATER_RST[h];
                else
                    heater_q[h] <= heater_d[h];
            end
        end
    endgenerate

    always_ff @(posedge MCLK_I)
    begin
        if (!RST_N_I)
            uv_q <= 1'b0;
        else
            uv_q <= uv_d;
    end

    // shutter is not on the forced-off list, it follows the host
    // shutter and pump keep their reset state until the host is up
    always_comb
    begin
        shutter_d = shutter_q;
        if (host_ok_q)
            shutter_d = SHUTTER_CMD_I;
    end

    always_ff @(posedge MCLK_I)
    begin
        if (!RST_N_I)
            shutter_q <= 1'b0;
        else
            shutter_q <= shutter_d;
    end

    // pump ignores the trip so sample flow continues
    always_comb
    begin
        pump_d = pump_q;
        if (host_ok_q)
            pump_d = PUMP_CMD_I;
    end

    always_ff @(posedge MCLK_I)
    begin
        if (!RST_N_I)
            pump_q <= 1'b0;
        else
            pump_q <= pump_d;
    end

    // ports are plain copies of the registers
    assign VALVE_O = valve_q;
    assign HEATER_O = heater_q;
    assign UV_O = uv_q;
    assign SHUTTER_O = shutter_q;
    assign PUMP_O = pump_q;
    assign HEARTBEAT_INDICATOR_O = hb_ind_q;

    // indicators mirror the driven outputs, so they show forced states too
    assign CHAMBER_HEATER_INDICATOR_O = heater_q[HEATER_CHAMBER];
    assign PERM_TUBE_HEATER_INDICATOR_O = heater_q[HEATER_PERM];
    assign ZERO_SPAN_VALVE_INDICATOR_O = valve_q[VALVE_ZERO_SPAN];
    assign SAMPLE_CAL_VALVE_INDICATOR_O = valve_q[VALVE_SAMPLE_CAL];
    assign SHUTTER_INDICATOR_O = shutter_q;
    assign WATCHDOG_TRIP_O = trip;
endmodule : relay_board_watchdog_status
`default_nettype wire

// >>> relay_board_watchdog_status_test.sv
`timescale 1ns/1ps
`default_nettype none
module relay_board_watchdog_status_test;
    logic MCLK_I = 0, RST_N_I = 0, HOST_READY_I = 0, alive = 0;
    logic UV_CMD_I = 1, SHUTTER_CMD_I = 1, PUMP_CMD_I = 1, HEARTBEAT_CMD_I;
    logic [7:0] VALVE_CMD_I = 8'hff, VALVE_O;
    logic [1:0] HEATER_CMD_I = 2'h3, HEATER_O;
    logic UV_O, SHUTTER_O, PUMP_O, HEARTBEAT_INDICATOR_O, SHUTTER_INDICATOR_O;
    logic CHAMBER_HEATER_INDICATOR_O, PERM_TUBE_HEATER_INDICATOR_O;
    logic ZERO_SPAN_VALVE_INDICATOR_O, SAMPLE_CAL_VALVE_INDICATOR_O;
    logic WATCHDOG_TRIP_O;
    logic [7:0] pats [3] = '{8'h01, 8'h02, 8'ha5};
    int failures = 0, cmp_count = 0;
    always #5 MCLK_I = ~MCLK_I;
    host_model host_model_i (.clk_i(MCLK_I), .en_i(alive),
        .hb_o(HEARTBEAT_CMD_I));
    // short stuck time keeps the run brief
    relay_board_watchdog_status #(.STUCK_CYCLES(32'd100))
        relay_board_watchdog_status_i (.*);
    task automatic chk(input string what, input logic [7:0] exp, got);
        cmp_count++;
        if (got !== exp)
        begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic test_done;
        $display("failures %0d comparisons %0d", failures, cmp_count);
        if (failures == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : test_done
    task automatic tick(input int n);
        repeat (n) @(posedge MCLK_I);
        #1;
    endtask : tick
    task automatic wait_trip(input logic lvl);
        for (int n = 0; n < 400 && WATCHDOG_TRIP_O !== lvl; n++)
            tick(1);
        if (WATCHDOG_TRIP_O !== lvl)
        begin
            chk("trip", 8'(lvl), 8'(WATCHDOG_TRIP_O));
            test_done();
        end
    endtask : wait_trip
    initial
    begin
        tick(6);
        chk("valve reset", 8'h00, VALVE_O);
        @(posedge MCLK_I);
        RST_N_I <= 1;
        tick(4);
        chk("valve unready", 8'h00, VALVE_O);
        @(posedge MCLK_I);
        HOST_READY_I <= 1;
        alive <= 1;
        foreach (pats[i])
        begin
            @(posedge MCLK_I);
            VALVE_CMD_I <= pats[i];
            HEATER_CMD_I <= 2'(i + 1);
            SHUTTER_CMD_I <= 1'(i);
            tick(4);
            chk("valve", pats[i], VALVE_O);
            chk("heat led", 8'(i + 1), 8'({PERM_TUBE_HEATER_INDICATOR_O,
                CHAMBER_HEATER_INDICATOR_O}));
            chk("span led", 8'(pats[i][0]),
                8'(ZERO_SPAN_VALVE_INDICATOR_O));
            chk("cal led", 8'(pats[i][1]),
                8'(SAMPLE_CAL_VALVE_INDICATOR_O));
            chk("shutter led", 8'(i % 2), 8'(SHUTTER_INDICATOR_O));
            chk("uv on", 8'h01, 8'(UV_O));
        end
        @(posedge MCLK_I);
        alive <= 0;
        wait_trip(1);
        tick(2);
        chk("valve trip", 8'h00, VALVE_O);
        chk("heat trip", 8'h00, 8'({UV_O, HEATER_O}));
        chk("pump trip", 8'h01, 8'(PUMP_O));
        chk("heat led trip", 8'h00, 8'({PERM_TUBE_HEATER_INDICATOR_O,
            CHAMBER_HEATER_INDICATOR_O}));
        tick(150);
        chk("trip held", 8'h01, 8'(WATCHDOG_TRIP_O));
        @(posedge MCLK_I);
        alive <= 1;
        wait_trip(0);
        tick(2);
        chk("valve resume", 8'ha5, VALVE_O);
        test_done();
    end
endmodule : relay_board_watchdog_status_test
`default_nettype wire

// >>> relay_wd_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module relay_wd_monitor
#(
    parameter logic [31:0] STUCK_CYCLES = 32'd100
)
(
    input wire logic MCLK_I,
    input wire logic RST_N_I,
    input wire logic PUMP_CMD_I,
    input wire logic [7:0] VALVE_O,
    input wire logic [1:0] HEATER_O,
    input wire logic UV_O,
    input wire logic PUMP_O,
    input wire logic HEARTBEAT_INDICATOR_O,
    input wire logic CHAMBER_HEATER_INDICATOR_O,
    input wire logic PERM_TUBE_HEATER_INDICATOR_O,
    input wire logic ZERO_SPAN_VALVE_INDICATOR_O,
    input wire logic SAMPLE_CAL_VALVE_INDICATOR_O,
    input wire logic WATCHDOG_TRIP_O
);
    logic hb_q;
    logic [31:0] still_q;
    always_ff @(posedge MCLK_I)
    begin
        hb_q <= HEARTBEAT_INDICATOR_O;
        still_q <= (!RST_N_I || hb_q != HEARTBEAT_INDICATOR_O) ?
            '0 : still_q + 1;
    end
    default clocking @(posedge MCLK_I); endclocking
    default disable iff (!RST_N_I);
    // slack of four covers the register stages around the counter
    a_stuck_trips: assert property (
        still_q >= STUCK_CYCLES + 4 |-> WATCHDOG_TRIP_O) else $error("no trip");
    a_trip_valves: assert property (
        WATCHDOG_TRIP_O |=> VALVE_O == 8'h00) else $error("valve on");
    a_trip_heat: assert property (
        WATCHDOG_TRIP_O |=> HEATER_O == 2'h0 && !UV_O) else $error("heat on");
    a_pump_runs: assert property (
        WATCHDOG_TRIP_O && PUMP_O |=> PUMP_O == $past(PUMP_CMD_I))
        else $error("pump");
    a_heat_leds: assert property (
        {PERM_TUBE_HEATER_INDICATOR_O, CHAMBER_HEATER_INDICATOR_O} == HEATER_O)
        else $error("heat led");
    a_span_led: assert property (
        ZERO_SPAN_VALVE_INDICATOR_O == VALVE_O[0]) else $error("span led");
    a_cal_led: assert property (
        SAMPLE_CAL_VALVE_INDICATOR_O == VALVE_O[1]) else $error("cal led");
    a_trip_holds: assert property (
        WATCHDOG_TRIP_O && $stable(HEARTBEAT_INDICATOR_O) |=> WATCHDOG_TRIP_O)
        else $error("trip drop");
    c_trip: cover property ($rose(WATCHDOG_TRIP_O));
    c_clear: cover property ($fell(WATCHDOG_TRIP_O));
    c_cal: cover property (VALVE_O[1] && HEATER_O[1]);
endmodule : relay_wd_monitor
bind relay_board_watchdog_status relay_wd_monitor
    #(.STUCK_CYCLES(STUCK_CYCLES)) relay_wd_monitor_i (.*);
`default_nettype wire

// >>> relay_wd_pkg.sv
package relay_wd_pkg;
    localparam int unsigned CLK_HZ = 100_000_000;
    // heartbeat stuck time, seconds
    localparam int unsigned STUCK_TIME_S = 30;
    localparam longint unsigned STUCK_CYCLES_DEF =
        longint'(STUCK_TIME_S) * longint'(CLK_HZ);
    localparam int unsigned CNT_W = 32;
    localparam int unsigned VALVE_UNITS = 2;
    localparam int unsigned VALVES_PER_UNIT = 4;
    localparam int unsigned VALVE_N = VALVE_UNITS * VALVES_PER_UNIT;
    localparam int unsigned HEATER_N = 2;
    localparam int unsigned HEATER_CHAMBER = 0;
    localparam int unsigned HEATER_PERM = 1;
    localparam int unsigned VALVE_ZERO_SPAN = 0;
    localparam int unsigned VALVE_SAMPLE_CAL = 1;
    localparam logic [VALVE_N-1:0] VALVE_RST = 8'h00;
    localparam logic [HEATER_N-1:0] HEATER_RST = 2'h0;
endpackage : relay_wd_pkg
